// [hdl/sfdtp_pkg.sv]
package sfdtp_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// management register offsets
	localparam logic [15:0] SFDTP_ADDR_CTRL = 16'h001F;
	localparam logic [15:0] SFDTP_ADDR_SKEW = 16'h0055;
	localparam logic [15:0] SFDTP_ADDR_SYNC = 16'h00E9;
	localparam logic [15:0] SFDTP_ADDR_RECEIVE_FRAME_CONFIG = 16'h0134;
	localparam logic [15:0] SFDTP_ADDR_MUX = 16'h01E0;
	localparam logic [15:0] SFDTP_ADDR_PHASE = 16'h01E1;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and magic values
	localparam logic [15:0] SFDTP_REG_RST = 16'h0000;
	localparam logic [15:0] SFDTP_SYNC_MAGIC = 16'hDF22;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int SFDTP_RESTART_BIT = 14;
	localparam int SFDTP_EMAC_BIT = 7;
	localparam int SFDTP_SKEW_MST_LSB = 4;
	localparam int SFDTP_SKEW_SLV_LSB = 0;
	localparam int SFDTP_SKEW_W = 4;
	localparam int SFDTP_MUX_RX_LSB = 0;
	localparam int SFDTP_MUX_TX_LSB = 4;
	localparam int SFDTP_MUX_W = 3;
	localparam int SFDTP_PHASE_TX_LSB = 0;
	localparam int SFDTP_PHASE_RX_LSB = 4;
	localparam int SFDTP_PHASE_W = 4;

	////////////////////////////////////////////////////////////////////////////////
	// pins, delay line and timing
	localparam int SFDTP_NPINS = 4;
	localparam int SFDTP_DLY_DEPTH = 32;
	localparam int SFDTP_DLY_IDX_W = 5;
	localparam int SFDTP_STEP_NS = 8;
	localparam int SFDTP_CLK_NS = 50;
	// a longest step rounds down, but never below one cycle
	localparam int SFDTP_STEP_CYC = (SFDTP_STEP_NS / SFDTP_CLK_NS < 1) ? 1 :
		SFDTP_STEP_NS / SFDTP_CLK_NS;
endpackage : sfdtp_pkg

// [hdl/sfdtp_if.sv]
`timescale 1ns/1ps
interface sfdtp_if;
	logic mgmt_req;
	logic mgmt_we;
	logic [15:0] mgmt_addr;
	logic [15:0] mgmt_wdata;
	logic [15:0] mgmt_rdata;
	logic mgmt_ack;
	logic [3:0] sfd_pin;

	modport dev (
		input mgmt_req,
		input mgmt_we,
		input mgmt_addr,
		input mgmt_wdata,
		output mgmt_rdata,
		output mgmt_ack,
		output sfd_pin
	);

	modport host (
		output mgmt_req,
		output mgmt_we,
		output mgmt_addr,
		output mgmt_wdata,
		input mgmt_rdata,
		input mgmt_ack,
		input sfd_pin
	);
endinterface : sfdtp_if

// [hdl/sfdtp_phy_end.sv]
`timescale 1ns/1ps
// What this block does
// - separate tx and rx delimiter pulses
// - tx at MAC lines, rx after line latency
// - programmable phase delays pulse, one 50 ns clock per step
// - pulses routed to pins by mux register
// - pulses suppressed unless extended MAC bit set
// - 1000M alignment adds latency before rx pulse
// - added latency fixed for one link once sync magic written
// - limit and report only in 1000M
// - software writes sync magic before link
// - restart bit re-establishes link, report cleared until the next link rise
// - master skew reported in bits 7:4
// - slave skew reported in bits 3:0
// - 100M variation random, no readout
module sfdtp_phy_end
	import sfdtp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	sfdtp_if.dev MGMT,
	input wire logic TX_DELIMITER_PULSE_IN,
	input wire logic RX_DELIMITER_PULSE_IN,
	input wire logic LINK_UP,
	input wire logic SPEED_1000,
	input wire logic MASTER_MODE,
	input wire logic [3:0] ALIGN_SKEW,
	output logic LINK_RESTART,
	output logic TX_DELIMITER_PULSE_PULSE,
	output logic RX_DELIMITER_PULSE_PULSE
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// pin select: 0 routes nowhere, 1..4 picks a pin
	function automatic logic [SFDTP_NPINS-1:0] pin_decode(input logic [SFDTP_MUX_W-1:0] sel);
		logic [SFDTP_NPINS-1:0] hot;
		hot = '0;
		for (int i = 0; i < SFDTP_NPINS; i++) begin
			if (sel == SFDTP_MUX_W'(i + 1)) begin
				hot[i] = 1'b1;
			end
		end
		return hot;
	endfunction : pin_decode

	function automatic logic [SFDTP_DLY_IDX_W-1:0] phase_taps(input logic [SFDTP_PHASE_W-1:0] ph);
		return SFDTP_DLY_IDX_W'(ph * SFDTP_STEP_CYC);
	endfunction : phase_taps

	////////////////////////////////////////////////////////////////////////////////
	// management registers

	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] sync_reg, sync_next;
	logic [15:0] receive_frame_config_reg, receive_frame_config_next;
	logic [15:0] mux_reg, mux_next;
	logic [15:0] phase_reg, phase_next;
	logic [15:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	logic restart_reg, restart_next;
	logic [15:0] skew_reg;
	logic take, wr;

	assign take = MGMT.mgmt_req & ~ack_reg;
	assign wr = take & MGMT.mgmt_we;

	always_comb begin
		ctrl_next = ctrl_reg;
		sync_next = sync_reg;
		receive_frame_config_next = receive_frame_config_reg;
		mux_next = mux_reg;
		phase_next = phase_reg;
		rdata_next = rdata_reg;
		restart_next = 1'b0;
		ack_next = take;
		if (wr) begin
			case (MGMT.mgmt_addr)
				SFDTP_ADDR_CTRL: begin
					// restart bit is self-clearing and never stored
					ctrl_next = MGMT.mgmt_wdata;
					ctrl_next[SFDTP_RESTART_BIT] = 1'b0;
					restart_next = MGMT.mgmt_wdata[SFDTP_RESTART_BIT];
				end
				SFDTP_ADDR_SYNC: sync_next = MGMT.mgmt_wdata;
				SFDTP_ADDR_RECEIVE_FRAME_CONFIG: receive_frame_config_next = MGMT.mgmt_wdata;
				SFDTP_ADDR_MUX: mux_next = MGMT.mgmt_wdata;
				SFDTP_ADDR_PHASE: phase_next = MGMT.mgmt_wdata;
				default: ;
			endcase
		end
		if (take) begin
			case (MGMT.mgmt_addr)
				SFDTP_ADDR_CTRL: rdata_next = ctrl_reg;
				SFDTP_ADDR_SKEW: rdata_next = skew_reg;
				SFDTP_ADDR_SYNC: rdata_next = sync_reg;
				SFDTP_ADDR_RECEIVE_FRAME_CONFIG: rdata_next = receive_frame_config_reg;
				SFDTP_ADDR_MUX: rdata_next = mux_reg;
				SFDTP_ADDR_PHASE: rdata_next = phase_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			ctrl_reg <= SFDTP_REG_RST;
			sync_reg <= SFDTP_REG_RST;
			receive_frame_config_reg <= SFDTP_REG_RST;
			mux_reg <= SFDTP_REG_RST;
			phase_reg <= SFDTP_REG_RST;
			rdata_reg <= SFDTP_REG_RST;
			ack_reg <= 1'b0;
			restart_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			sync_reg <= sync_next;
			receive_frame_config_reg <= receive_frame_config_next;
			mux_reg <= mux_next;
			phase_reg <= phase_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
			restart_reg <= restart_next;
		end
	end

	assign MGMT.mgmt_ack = ack_reg;
	assign MGMT.mgmt_rdata = rdata_reg;
	assign LINK_RESTART = restart_reg;

	////////////////////////////////////////////////////////////////////////////////
	// alignment latency capture and skew report

	logic link_d_reg, link_d_next;
	logic skew_vld_reg, skew_vld_next;
	logic [3:0] align_reg, align_next;
	logic [15:0] skew_next;
	logic [3:0] rx_extra;
	logic link_rise;

	assign link_rise = LINK_UP & ~link_d_reg;

	always_comb begin
		link_d_next = LINK_UP;
		skew_vld_next = skew_vld_reg;
		align_next = align_reg;
		skew_next = skew_reg;
		// a fresh link in the restart cycle outranks the clear
		if (!LINK_UP || (restart_reg && !link_rise)) begin
			// link gone or restart requested: old figure no longer describes anything
			skew_vld_next = 1'b0;
			align_next = '0;
			skew_next = '0;
		end else if (link_rise) begin
			if (SPEED_1000 && sync_reg == SFDTP_SYNC_MAGIC) begin
				skew_vld_next = 1'b1;
				align_next = ALIGN_SKEW;
				skew_next = '0;
				if (MASTER_MODE) begin
					skew_next[SFDTP_SKEW_MST_LSB +: SFDTP_SKEW_W] = ALIGN_SKEW;
				end else begin
					skew_next[SFDTP_SKEW_SLV_LSB +: SFDTP_SKEW_W] = ALIGN_SKEW;
				end
			end else begin
				// 100M or uninitialised: nothing to report
				skew_vld_next = 1'b0;
				skew_next = '0;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			link_d_reg <= 1'b0;
			skew_vld_reg <= 1'b0;
			align_reg <= '0;
			skew_reg <= SFDTP_REG_RST;
		end else begin
			link_d_reg <= link_d_next;
			skew_vld_reg <= skew_vld_next;
			align_reg <= align_next;
			skew_reg <= skew_next;
		end
	end

	// without init the live figure is used, so it may wander between frames
	always_comb begin
		if (skew_vld_reg) begin
			rx_extra = align_reg;
		end else if (SPEED_1000 && LINK_UP) begin
			rx_extra = ALIGN_SKEW;
		end else begin
			rx_extra = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// delimiter pulse delay lines

	logic tx_in_d_reg, tx_in_d_next, rx_in_d_reg, rx_in_d_next;
	logic [SFDTP_DLY_DEPTH-1:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
	logic tx_pulse_reg, tx_pulse_next, rx_pulse_reg, rx_pulse_next;
	logic [SFDTP_NPINS-1:0] pin_reg, pin_next;
	logic [SFDTP_DLY_IDX_W-1:0] tx_tap, rx_tap;
	logic enable;

	assign enable = receive_frame_config_reg[SFDTP_EMAC_BIT];
	assign tx_tap = phase_taps(phase_reg[SFDTP_PHASE_TX_LSB +: SFDTP_PHASE_W]);
	assign rx_tap = SFDTP_DLY_IDX_W'(phase_taps(phase_reg[SFDTP_PHASE_RX_LSB +: SFDTP_PHASE_W])
		+ SFDTP_DLY_IDX_W'(rx_extra));

	always_comb begin
		tx_in_d_next = TX_DELIMITER_PULSE_IN;
		rx_in_d_next = RX_DELIMITER_PULSE_IN;
		// edge detect so a held strobe still yields one pulse
		tx_sh_next = {tx_sh_reg[SFDTP_DLY_DEPTH-2:0], TX_DELIMITER_PULSE_IN & ~tx_in_d_reg};
		rx_sh_next = {rx_sh_reg[SFDTP_DLY_DEPTH-2:0], RX_DELIMITER_PULSE_IN & ~rx_in_d_reg};
		tx_pulse_next = enable & tx_sh_next[tx_tap];
		rx_pulse_next = enable & rx_sh_next[rx_tap];
		pin_next = ({SFDTP_NPINS{tx_pulse_next}} &
			pin_decode(mux_reg[SFDTP_MUX_TX_LSB +: SFDTP_MUX_W])) |
			({SFDTP_NPINS{rx_pulse_next}} &
			pin_decode(mux_reg[SFDTP_MUX_RX_LSB +: SFDTP_MUX_W]));
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			tx_in_d_reg <= 1'b0;
			rx_in_d_reg <= 1'b0;
			tx_sh_reg <= '0;
			rx_sh_reg <= '0;
			tx_pulse_reg <= 1'b0;
			rx_pulse_reg <= 1'b0;
			pin_reg <= '0;
		end else begin
			tx_in_d_reg <= tx_in_d_next;
			rx_in_d_reg <= rx_in_d_next;
			tx_sh_reg <= tx_sh_next;
			rx_sh_reg <= rx_sh_next;
			tx_pulse_reg <= tx_pulse_next;
			rx_pulse_reg <= rx_pulse_next;
			pin_reg <= pin_next;
		end
	end

	assign TX_DELIMITER_PULSE_PULSE = tx_pulse_reg;
	assign RX_DELIMITER_PULSE_PULSE = rx_pulse_reg;
	assign MGMT.sfd_pin = pin_reg;

endmodule : sfdtp_phy_end

// [hdl/sfdtp_host_end.sv]
`timescale 1ns/1ps
module sfdtp_host_end
	import sfdtp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	sfdtp_if.host MGMT,
	input wire logic START,
	input wire logic RESTART_EN,
	input wire logic [15:0] MUX_VALUE,
	input wire logic [15:0] PHASE_VALUE,
	input wire logic READ_SKEW,
	output logic BUSY,
	output logic DONE,
	output logic SKEW_VALID,
	output logic [15:0] SKEW_STATUS,
	output logic [3:0] SFD_PINS
);

	typedef enum {
		SFDTP_IDLE, SFDTP_WR_SYNC, SFDTP_WR_RECEIVE_FRAME_CONFIG, SFDTP_WR_MUX,
		SFDTP_WR_PHASE, SFDTP_WR_CTRL, SFDTP_RD_SKEW
	} sfdtp_hstate_t;

	////////////////////////////////////////////////////////////////////////////////
	// init sequencer: sync magic goes first so the coming link is measured

	sfdtp_hstate_t state_reg, state_next;
	logic restart_reg, restart_next;
	logic [15:0] mux_reg, mux_next, phase_reg, phase_next;
	logic [15:0] skew_reg, skew_next;
	logic done_reg, done_next, skv_reg, skv_next;
	logic [3:0] pins_reg;

	always_comb begin
		state_next = state_reg;
		restart_next = restart_reg;
		mux_next = mux_reg;
		phase_next = phase_reg;
		skew_next = skew_reg;
		done_next = 1'b0;
		skv_next = 1'b0;
		case (state_reg)
			SFDTP_IDLE: begin
				if (START) begin
					state_next = SFDTP_WR_SYNC;
					restart_next = RESTART_EN;
					mux_next = MUX_VALUE;
					phase_next = PHASE_VALUE;
				end else if (READ_SKEW) begin
					state_next = SFDTP_RD_SKEW;
				end
			end
			SFDTP_WR_SYNC: if (MGMT.mgmt_ack) state_next = SFDTP_WR_RECEIVE_FRAME_CONFIG;
			SFDTP_WR_RECEIVE_FRAME_CONFIG: if (MGMT.mgmt_ack) state_next = SFDTP_WR_MUX;
			SFDTP_WR_MUX: if (MGMT.mgmt_ack) state_next = SFDTP_WR_PHASE;
			SFDTP_WR_PHASE: begin
				if (MGMT.mgmt_ack) begin
					state_next = restart_reg ? SFDTP_WR_CTRL : SFDTP_IDLE;
					done_next = ~restart_reg;
				end
			end
			SFDTP_WR_CTRL: begin
				if (MGMT.mgmt_ack) begin
					state_next = SFDTP_IDLE;
					done_next = 1'b1;
				end
			end
			SFDTP_RD_SKEW: begin
				if (MGMT.mgmt_ack) begin
					state_next = SFDTP_IDLE;
					skew_next = MGMT.mgmt_rdata;
					skv_next = 1'b1;
				end
			end
			default: state_next = SFDTP_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			state_reg <= SFDTP_IDLE;
			restart_reg <= 1'b0;
			mux_reg <= SFDTP_REG_RST;
			phase_reg <= SFDTP_REG_RST;
			skew_reg <= SFDTP_REG_RST;
			done_reg <= 1'b0;
			skv_reg <= 1'b0;
			pins_reg <= '0;
		end else begin
			state_reg <= state_next;
			restart_reg <= restart_next;
			mux_reg <= mux_next;
			phase_reg <= phase_next;
			skew_reg <= skew_next;
			done_reg <= done_next;
			skv_reg <= skv_next;
			pins_reg <= MGMT.sfd_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// request drive, decoded from state

	always_comb begin
		MGMT.mgmt_req = 1'b1;
		MGMT.mgmt_we = 1'b1;
		MGMT.mgmt_addr = '0;
		MGMT.mgmt_wdata = '0;
		case (state_reg)
			SFDTP_WR_SYNC: begin
				MGMT.mgmt_addr = SFDTP_ADDR_SYNC;
				MGMT.mgmt_wdata = SFDTP_SYNC_MAGIC;
			end
			SFDTP_WR_RECEIVE_FRAME_CONFIG: begin
				MGMT.mgmt_addr = SFDTP_ADDR_RECEIVE_FRAME_CONFIG;
				MGMT.mgmt_wdata[SFDTP_EMAC_BIT] = 1'b1;
			end
			SFDTP_WR_MUX: begin
				MGMT.mgmt_addr = SFDTP_ADDR_MUX;
				MGMT.mgmt_wdata = mux_reg;
			end
			SFDTP_WR_PHASE: begin
				MGMT.mgmt_addr = SFDTP_ADDR_PHASE;
				MGMT.mgmt_wdata = phase_reg;
			end
			SFDTP_WR_CTRL: begin
				MGMT.mgmt_addr = SFDTP_ADDR_CTRL;
				MGMT.mgmt_wdata[SFDTP_RESTART_BIT] = 1'b1;
			end
			SFDTP_RD_SKEW: begin
				MGMT.mgmt_we = 1'b0;
				MGMT.mgmt_addr = SFDTP_ADDR_SKEW;
			end
			default: begin
				MGMT.mgmt_req = 1'b0;
				MGMT.mgmt_we = 1'b0;
			end
		endcase
	end

	assign BUSY = (state_reg != SFDTP_IDLE);
	assign DONE = done_reg;
	assign SKEW_VALID = skv_reg;
	assign SKEW_STATUS = skew_reg;
	assign SFD_PINS = pins_reg;

endmodule : sfdtp_host_end

// [verification/sfdtp_properties.sv]
`timescale 1ns/1ps
module sfdtp_properties
	import sfdtp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic mgmt_req,
	input wire logic mgmt_we,
	input wire logic [15:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_ack,
	input wire logic [3:0] sfd_pin
);
	logic take, rd_skew, magic_reg, magic_next, emac_reg, emac_next;
	logic [7:0] mux_reg, mux_next;
	logic [3:0] mask;

	function automatic logic [3:0] sel(input logic [2:0] v);
		return (v == 3'h0 || v > 3'h4) ? 4'h0 : 4'h1 << (v - 3'h1);
	endfunction : sel

	////////////////////////////////////////////////////////////////////////////////
	// shadow of the written configuration
	assign take = mgmt_req && !mgmt_ack;
	assign rd_skew = mgmt_ack && !mgmt_we && mgmt_addr == SFDTP_ADDR_SKEW;
	assign mask = sel(mux_reg[2:0]) | sel(mux_reg[6:4]);

	always_comb begin
		magic_next = magic_reg;
		emac_next = emac_reg;
		mux_next = mux_reg;
		if (take && mgmt_we) begin
			if (mgmt_addr == SFDTP_ADDR_SYNC)
				magic_next = mgmt_wdata == SFDTP_SYNC_MAGIC;
			if (mgmt_addr == SFDTP_ADDR_RECEIVE_FRAME_CONFIG)
				emac_next = mgmt_wdata[SFDTP_EMAC_BIT];
			if (mgmt_addr == SFDTP_ADDR_MUX)
				mux_next = mgmt_wdata[7:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			magic_reg <= 1'b0;
			emac_reg <= 1'b0;
			mux_reg <= 8'h00;
		end else begin
			magic_reg <= magic_next;
			emac_reg <= emac_next;
			mux_reg <= mux_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	a_ack_after_take: assert property (take |=> mgmt_ack)
		else $error("no ack one cycle after take");
	a_ack_one_cycle: assert property (mgmt_ack |=> !mgmt_ack)
		else $error("ack longer than one cycle");
	a_ack_held_req: assert property (mgmt_ack |-> mgmt_req && $past(mgmt_req))
		else $error("ack without held request");
	a_magic_before_cfg: assert property (
		take && mgmt_we && mgmt_addr == SFDTP_ADDR_RECEIVE_FRAME_CONFIG |-> magic_reg)
		else $error("config written before sync value");
	a_skew_no_magic: assert property (rd_skew && !magic_reg |-> mgmt_rdata == 16'h0000)
		else $error("skew reported without sync value");
	a_skew_upper_zero: assert property (rd_skew |-> mgmt_rdata[15:8] == 8'h00)
		else $error("skew upper byte not zero");
	a_skew_one_field: assert property (
		rd_skew |-> mgmt_rdata[7:4] == 4'h0 || mgmt_rdata[3:0] == 4'h0)
		else $error("both skew fields set");
	a_pins_gated: assert property (sfd_pin != 4'h0 |-> emac_reg || $past(emac_reg))
		else $error("pin pulse while disabled");
	a_pins_routed: assert property ((sfd_pin & ~mask) == 4'h0)
		else $error("pulse on unselected pin");

	c_skew_read: cover property (rd_skew && mgmt_rdata != 16'h0000);
	c_pin_pulse: cover property (sfd_pin != 4'h0);
	c_restart: cover property (take && mgmt_we && mgmt_addr == SFDTP_ADDR_CTRL);
endmodule : sfdtp_properties

// [verification/test_sfd_timestamp_pulse_skew_report.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITHI(s) begin for (n = 0; n < 100 && (s) !== 1'b1; n++) @(posedge sys_clk) #1; \
	if (n == 100) begin n_fail++; report_and_stop(); end end
module test_sfd_timestamp_pulse_skew_report import sfdtp_pkg::*;;
	typedef struct {logic sp; logic ms; logic [3:0] al; logic [15:0] mux; logic [15:0] ph;
		logic [15:0] skew; int rx_tap;} sfdtp_row_t;
	// rx_tap is rx phase plus the alignment latched at link rise
	sfdtp_row_t rows[4] = '{
		'{1'b1, 1'b1, 4'h2, 16'h0021, 16'h0030, 16'h0020, 5},
		'{1'b1, 1'b0, 4'h1, 16'h0043, 16'h0005, 16'h0001, 1},
		'{1'b0, 1'b0, 4'h7, 16'h0014, 16'h00F0, 16'h0000, 15},
		'{1'b1, 1'b1, 4'hF, 16'h0044, 16'h000F, 16'h00F0, 15}
	};
	logic sys_clk = 1'b0, reset = 1'b1, start = 1'b0, restart_en = 1'b0, read_skew = 1'b0;
	logic tx_in = 1'b0, rx_in = 1'b0, link_up = 1'b0, speed_1000 = 1'b0, master_mode = 1'b0;
	logic [3:0] align_skew = 4'h0;
	logic [15:0] mux_value = 16'h0000, phase_value = 16'h0000;
	logic link_restart, tx_pulse, rx_pulse, busy, done, skew_valid;
	logic [15:0] skew_status;
	logic [3:0] sfd_pins, pin;
	logic [25:0] outs_all;
	assign outs_all = {busy, done, skew_valid, skew_status, sfd_pins, link_restart, tx_pulse,
		rx_pulse};
	int n_fail = 0, total_checks = 0, n_restart = 0, n, r;

	sfdtp_if bus ();
	sfdtp_phy_end i_sfdtp_phy_end (.SYS_CLK(sys_clk), .RESET(reset), .MGMT(bus),
		.TX_DELIMITER_PULSE_IN(tx_in), .RX_DELIMITER_PULSE_IN(rx_in), .LINK_UP(link_up), .SPEED_1000(speed_1000),
		.MASTER_MODE(master_mode), .ALIGN_SKEW(align_skew), .LINK_RESTART(link_restart),
		.TX_DELIMITER_PULSE_PULSE(tx_pulse), .RX_DELIMITER_PULSE_PULSE(rx_pulse));
	sfdtp_host_end i_sfdtp_host_end (.SYS_CLK(sys_clk), .RESET(reset), .MGMT(bus),
		.START(start), .RESTART_EN(restart_en), .MUX_VALUE(mux_value),
		.PHASE_VALUE(phase_value), .READ_SKEW(read_skew), .BUSY(busy), .DONE(done),
		.SKEW_VALID(skew_valid), .SKEW_STATUS(skew_status), .SFD_PINS(sfd_pins));
	sfdtp_properties i_sfdtp_properties (.SYS_CLK(sys_clk), .RESET(reset),
		.mgmt_req(bus.mgmt_req), .mgmt_we(bus.mgmt_we), .mgmt_addr(bus.mgmt_addr),
		.mgmt_wdata(bus.mgmt_wdata), .mgmt_rdata(bus.mgmt_rdata), .mgmt_ack(bus.mgmt_ack),
		.sfd_pin(bus.sfd_pin));

	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (link_restart === 1'b1) n_restart++;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] sel(input logic [2:0] v);
		return (v == 3'h0) ? 4'h0 : 4'h1 << (v - 3'h1);
	endfunction : sel

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// k 0 runs the init sequence, k 1 reads the skew status
	task automatic op(input int k);
		@(negedge sys_clk);
		if (k == 0) start = 1'b1; else read_skew = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
		read_skew = 1'b0;
		if (k == 0) `WAITHI(done) else `WAITHI(skew_valid)
	endtask : op

	task automatic measure(input logic do_rx);
		@(negedge sys_clk);
		if (do_rx) rx_in = 1'b1; else tx_in = 1'b1;
		n = 0;
		pin = 4'h0;
		for (int k = 1; k < 40 && n == 0; k++) begin
			@(posedge sys_clk) #1;
			if ((do_rx ? rx_pulse : tx_pulse) === 1'b1) begin
				n = k;
				pin = bus.sfd_pin;
			end
		end
		@(posedge sys_clk) #1;
		if (n != 0) begin
			`CHK(do_rx ? rx_pulse : tx_pulse, 1'b0)
			`CHK(sfd_pins, pin)
		end
		@(negedge sys_clk);
		rx_in = 1'b0;
		tx_in = 1'b0;
	endtask : measure

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		@(posedge sys_clk) #1;
		`CHK(outs_all, 26'h000_0000)
		op(1);
		`CHK(skew_status, 16'h0000)
		measure(1'b0);
		`CHK(n, 0)
		$display("reset test done");
		for (r = 0; r < 4; r++) begin
			@(negedge sys_clk);
			link_up = 1'b0;
			speed_1000 = rows[r].sp;
			master_mode = rows[r].ms;
			align_skew = rows[r].al;
			mux_value = rows[r].mux;
			phase_value = rows[r].ph;
			op(0);
			@(negedge sys_clk);
			link_up = 1'b1;
			@(negedge sys_clk);
			// a live value leaking through would shift the rx pulse
			align_skew = ~rows[r].al;
			op(1);
			`CHK(skew_status, rows[r].skew)
			measure(1'b0);
			`CHK(n, rows[r].ph[3:0] + 1)
			`CHK(pin, sel(rows[r].mux[6:4]))
			measure(1'b1);
			`CHK(n, rows[r].rx_tap + 1)
			`CHK(pin, sel(rows[r].mux[2:0]))
			$display("row %0d done", r);
		end
		restart_en = 1'b1;
		n_restart = 0;
		op(0);
		`CHK(n_restart, 1)
		op(1);
		`CHK(skew_status, 16'h0000)
		@(negedge sys_clk);
		link_up = 1'b0;
		align_skew = 4'h3;
		@(negedge sys_clk);
		link_up = 1'b1;
		op(1);
		`CHK(skew_status, 16'h0030)
		$display("restart test done");
		// reset in mid-run, with the link still up
		@(negedge sys_clk);
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		@(posedge sys_clk) #1;
		`CHK(outs_all, 26'h000_0000)
		op(1);
		`CHK(skew_status, 16'h0000)
		measure(1'b1);
		`CHK(n, 0)
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule : test_sfd_timestamp_pulse_skew_report
